// >>> src/lc_ctrl_params.svh
// named constants of the line controller control bank
// assumes inclusion by bare name from the divider, the register bank and the bench
`ifndef LC_CTRL_PARAMS_SVH
`define LC_CTRL_PARAMS_SVH

// register offsets
`define LC_OFF_LINE_CTRL   8'h00
`define LC_OFF_TX_CTRL     8'h01
`define LC_OFF_DIAG_CTRL   8'h02
`define LC_OFF_COMMAND     8'h03
`define LC_OFF_LINE_STAT   8'h04

// reset values
`define LC_RST_LINE_CTRL   8'h00
`define LC_RST_DIAG_CTRL   8'h00
`define LC_RST_RETRY       4'h0
// revision code reported in the transmit control register; value arbitrary
`define LC_REVISION_CODE   3'h5

// timing
`define LC_TS_PRESCALE     9'h010
`define LC_SDC_BASE        22'h000040
`define LC_DIAG_PULSE_TS   2'h3
`define LC_CMD_MAX_DELAY_TS 6

`endif

// >>> src/lc_ctrl_pkg.sv
// shared types of the line controller control bank
// assumes nothing beyond a SystemVerilog compiler
package lc_ctrl_pkg;

    // power and bus mode of the controller
    typedef enum logic [1:0] {
        LC_SLEEP,
        LC_IDLE,
        LC_ACTIVE
    } lc_mode_t;

    // receive source selection
    typedef enum logic [1:0] {
        LC_SRC_DIFF,
        LC_SRC_COMP,
        LC_SRC_TRUE,
        LC_SRC_AUTO
    } lc_src_t;

endpackage

// >>> src/lc_tick_div.sv
// programmable divider producing a one-cycle tick every i_period steps
// assumes a synchronous clear and a step strobe from the same clock
`timescale 1ns/100ps
`include "lc_ctrl_params.svh"

module lc_tick_div #(
    parameter int W = 9
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    // control
    input  wire logic         i_clr,
    input  wire logic         i_en,
    input  wire logic         i_step,
    input  wire logic [W-1:0] i_period,
    // output
    output logic              o_tick
);

    logic [W-1:0] cnt_q;   // steps counted so far
    logic         last;    // final step of a period

    assign last = (cnt_q >= i_period - W'(1));

    // *****************************
    // count steps, wrap at period
    // *****************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (i_clr || !i_en) begin
                cnt_q  <= '0;
                o_tick <= 1'b0;
            end else begin
                o_tick <= i_step && last;
                if (i_step) begin
                    cnt_q <= last ? '0 : cnt_q + W'(1);
                end
            end
        end
    end

endmodule

// >>> src/lc_ctrl_regs.sv
// control and command register bank of a serial bus line controller
// assumes a multiplexed 8-bit host bus on pins and a protocol core
// on the same clock for the transmit and diagnosis handshakes
`timescale 1ns/100ps
`include "lc_ctrl_params.svh"

module lc_ctrl_regs
    import lc_ctrl_pkg::*;
#(
    parameter int TS_W  = 9,
    parameter int SDC_W = 22
) (
    // clock, reset, enable
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    // host multiplexed bus pins
    input  wire logic       i_ale,
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [7:0] i_ad,
    output logic      [7:0] o_ad,
    output logic            o_ad_oe,
    // receive line pins
    input  wire logic       i_rx_line_diff,
    input  wire logic       i_rx_line_true,
    input  wire logic       i_rx_line_comp,
    // transmit line pin
    output logic            o_txd,
    output logic            o_txd_oe,
    // protocol core, same clock
    input  wire logic       i_tx_dominant,
    input  wire logic       i_tx_busy,
    input  wire logic       i_attempt_done,
    input  wire logic       i_attempt_err,
    input  wire logic       i_attempt_contend,
    input  wire logic [2:0] i_diag_status,
    input  wire logic       i_tx_going,
    input  wire logic       i_rx_going,
    // towards protocol core and diagnosis
    output logic            o_rx_bus,
    output logic            o_timeslot_tick,
    output logic            o_sync_diag_clock,
    output logic            o_transmit_in_progress,
    output logic            o_diag_active,
    output logic            o_pulse_code,
    output logic            o_module_autonomous,
    output logic      [3:0] o_retry_count,
    output logic            o_retry_give_up,
    output logic            o_rearbitrate,
    output logic            o_bus_enable,
    output logic            o_osc_run
);

    // *****************************
    // pin synchronisers
    // *****************************
    logic [11:0] pin1_q;   // first stage, read only by second
    logic [11:0] pin2_q;   // second stage
    logic        wr_n_d1_q; // delayed write strobe for edge detect
    logic [2:0]  rx1_q;    // receive lines first stage
    logic [2:0]  rx2_q;    // receive lines second stage

    // two flops on every pin input
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin1_q    <= 12'hE00;
            pin2_q    <= 12'hE00;
            wr_n_d1_q <= 1'b1;
            rx1_q     <= 3'h7;
            rx2_q     <= 3'h7;
        end else if (i_ce) begin
            pin1_q    <= {i_wr_n, i_rd_n, i_cs_n, i_ale, i_ad};
            pin2_q    <= pin1_q;
            wr_n_d1_q <= pin2_q[11];
            rx1_q     <= {i_rx_line_comp, i_rx_line_true, i_rx_line_diff};
            rx2_q     <= rx1_q;
        end
    end

    logic [7:0] ad_s;      // synchronised address/data
    logic       ale_s;     // synchronised latch enable
    logic       cs_s;      // chip selected, active high
    logic       rd_s;      // read strobe, active high
    logic       wr_rise;   // end of a write strobe

    assign ad_s    = pin2_q[7:0];
    assign ale_s   = pin2_q[8];
    assign cs_s    = ~pin2_q[9];
    assign rd_s    = ~pin2_q[10];
    assign wr_rise = pin2_q[11] & ~wr_n_d1_q;

    // *****************************
    // registers and state
    // *****************************
    logic [7:0] addr_q;        // latched address
    logic [7:0] line_ctrl_q;   // line control
    logic [4:0] tx_ctrl_q;     // retry limit and module kind
    logic [7:0] diag_ctrl_q;   // diagnosis control
    lc_mode_t   mode_q;        // sleep, idle or active
    logic       srst_q;        // soft reset pulse
    logic [3:0] cmd_pend_q;    // sleep, idle, activate, rearbitrate
    logic       manual_q;      // manual diagnosis tick pending
    logic       rearb_q;       // rearbitrate armed
    logic [3:0] retry_q;       // retries done
    logic [1:0] pulse_cnt_q;   // timeslots left in diagnosis pulse

    // field views
    logic [3:0] rate_divider;
    logic       pulse_code_sel;
    logic       tx_invert;
    logic       rx_invert;
    logic [3:0] retry_limit;
    logic       module_kind_sel;
    logic [3:0] diag_clock_divider;
    logic       diag_mode_hi;
    logic       diag_mode_lo;
    logic       tx_progress_enable;
    logic       diag_divider_enable;

    assign rate_divider        = line_ctrl_q[7:4];
    assign pulse_code_sel      = line_ctrl_q[3];
    assign tx_invert           = line_ctrl_q[1];
    assign rx_invert           = line_ctrl_q[0];
    assign retry_limit         = tx_ctrl_q[4:1];
    assign module_kind_sel     = tx_ctrl_q[0];
    assign diag_clock_divider  = diag_ctrl_q[7:4];
    assign diag_mode_hi        = diag_ctrl_q[3];
    assign diag_mode_lo        = diag_ctrl_q[2];
    assign tx_progress_enable  = diag_ctrl_q[1];
    assign diag_divider_enable = diag_ctrl_q[0];

    // *****************************
    // address decode
    // *****************************
    logic wr_line;     // write to line control
    logic wr_tx;       // write to transmit control
    logic wr_diag;     // write to diagnosis control
    logic wr_cmd;      // write to command
    logic rd_hit;      // readable register addressed
    logic [7:0] rdata; // read mux
    logic [7:0] line_stat;

    assign wr_line = wr_rise && cs_s && (addr_q == `LC_OFF_LINE_CTRL);
    assign wr_tx   = wr_rise && cs_s && (addr_q == `LC_OFF_TX_CTRL);
    assign wr_diag = wr_rise && cs_s && (addr_q == `LC_OFF_DIAG_CTRL);
    assign wr_cmd  = wr_rise && cs_s && (addr_q == `LC_OFF_COMMAND);

    assign line_stat = {1'b0, (mode_q == LC_SLEEP), (mode_q == LC_IDLE),
                        i_diag_status, i_tx_going, i_rx_going};

    assign rd_hit = (addr_q == `LC_OFF_LINE_CTRL) || (addr_q == `LC_OFF_TX_CTRL)
                 || (addr_q == `LC_OFF_DIAG_CTRL) || (addr_q == `LC_OFF_LINE_STAT);

    assign rdata = (addr_q == `LC_OFF_LINE_CTRL) ? line_ctrl_q :
                   (addr_q == `LC_OFF_TX_CTRL)   ? {tx_ctrl_q[4:1], `LC_REVISION_CODE,
                                                    tx_ctrl_q[0]} :
                   (addr_q == `LC_OFF_DIAG_CTRL) ? diag_ctrl_q :
                   (addr_q == `LC_OFF_LINE_STAT) ? line_stat : 8'h00;

    // address latch and read drive
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_q  <= 8'h00;
            o_ad    <= 8'h00;
            o_ad_oe <= 1'b0;
        end else if (i_ce) begin
            if (ale_s) begin
                addr_q <= ad_s;
            end
            o_ad    <= rdata;
            o_ad_oe <= cs_s && rd_s && !ale_s && rd_hit;
        end
    end

    // *****************************
    // software writable registers
    // *****************************
    // configuration writes; reserved bit 2 kept at zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            line_ctrl_q <= `LC_RST_LINE_CTRL;
            tx_ctrl_q   <= 5'h00;
            diag_ctrl_q <= `LC_RST_DIAG_CTRL;
        end else if (i_ce) begin
            if (srst_q) begin
                line_ctrl_q <= `LC_RST_LINE_CTRL;
                tx_ctrl_q   <= 5'h00;
                diag_ctrl_q <= `LC_RST_DIAG_CTRL;
            end else begin
                if (wr_line) begin
                    line_ctrl_q <= {ad_s[7:3], 1'b0, ad_s[1:0]};
                end
                if (wr_tx) begin
                    tx_ctrl_q <= {ad_s[7:4], ad_s[0]};
                end
                if (wr_diag) begin
                    diag_ctrl_q <= ad_s;
                end
            end
        end
    end

    // *****************************
    // command register
    // *****************************
    logic ts_tick;    // one timeslot elapsed
    logic sdc_tick;   // automatic diagnosis divider tick
    logic [3:0] cmd_new;    // command bits requested this cycle
    logic [3:0] cmd_done;   // pending bits consumed this cycle

    assign cmd_new  = wr_cmd ? ad_s[6:3] : 4'h0;
    assign cmd_done = {{3{ts_tick || mode_q == LC_SLEEP}}, ts_tick};

    // commands other than soft reset wait for the next timeslot, but mode commands apply at once in sleep; keeps mode changes aligned
    // with bit time, and a timeslot is far below the allowed delay
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            srst_q     <= 1'b0;
            cmd_pend_q <= 4'h0;
            manual_q   <= 1'b0;
            mode_q     <= LC_IDLE;
        end else if (i_ce) begin
            srst_q <= wr_cmd && ad_s[7] && !srst_q;
            if (srst_q) begin
                cmd_pend_q <= 4'h0;
                manual_q   <= 1'b0;
                mode_q     <= LC_IDLE;
            end else begin
                // ones request, zeros ignored
                // a request landing on an executing timeslot is kept
                cmd_pend_q <= (cmd_pend_q & ~cmd_done) | cmd_new;
                manual_q   <= (manual_q && !ts_tick) || (wr_cmd && ad_s[0]);
                if (ts_tick || mode_q == LC_SLEEP) begin
                    if (cmd_pend_q[1]) begin
                        mode_q <= LC_ACTIVE;
                    end else if (cmd_pend_q[2]) begin
                        mode_q <= LC_IDLE;
                    end else if (cmd_pend_q[3] && mode_q != LC_SLEEP) begin
                        mode_q <= LC_SLEEP;
                    end
                end
            end
        end
    end

    // *****************************
    // clock dividers
    // *****************************
    logic [TS_W-1:0]  ts_period;   // crystal cycles per timeslot
    logic [SDC_W-1:0] sdc_period;  // timeslots per diagnosis period

    assign ts_period  = (rate_divider == 4'h0) ? (`LC_TS_PRESCALE << 4)
                      : (`LC_TS_PRESCALE * TS_W'(rate_divider));
    assign sdc_period = `LC_SDC_BASE << diag_clock_divider;

    lc_tick_div #(.W(TS_W)) u_ts_div (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_ce     (i_ce),
        .i_clr    (srst_q),
        .i_en     (mode_q != LC_SLEEP),
        .i_step   (1'b1),
        .i_period (ts_period),
        .o_tick   (ts_tick)
    );

    lc_tick_div #(.W(SDC_W)) u_sdc_div (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_ce     (i_ce),
        .i_clr    (srst_q),
        .i_en     (diag_divider_enable && mode_q != LC_SLEEP),
        .i_step   (ts_tick),
        .i_period (sdc_period),
        .o_tick   (sdc_tick)
    );

    // *****************************
    // diagnosis clock pulse
    // *****************************
    // three timeslot edges guarantee two whole timeslots high
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pulse_cnt_q <= 2'h0;
        end else if (i_ce) begin
            if (srst_q) begin
                pulse_cnt_q <= 2'h0;
            end else if (pulse_cnt_q == 2'h0 && (sdc_tick || (ts_tick && manual_q))) begin
                pulse_cnt_q <= `LC_DIAG_PULSE_TS;
            end else if (ts_tick && pulse_cnt_q != 2'h0) begin
                pulse_cnt_q <= pulse_cnt_q - 2'h1;
            end
        end
    end

    // *****************************
    // retry counter
    // *****************************
    logic at_limit;   // retry budget used up
    assign at_limit = (retry_q >= retry_limit);

    // retry count, give up and rearbitration
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            retry_q         <= `LC_RST_RETRY;
            rearb_q         <= 1'b0;
            o_retry_give_up <= 1'b0;
            o_rearbitrate   <= 1'b0;
        end else if (i_ce) begin
            o_retry_give_up <= 1'b0;
            o_rearbitrate   <= 1'b0;
            if (srst_q) begin
                retry_q <= `LC_RST_RETRY;
                rearb_q <= 1'b0;
            end else begin
                if (i_attempt_done) begin
                    if (rearb_q) begin
                        retry_q       <= `LC_RST_RETRY;
                        rearb_q       <= 1'b0;
                        o_rearbitrate <= 1'b1;
                    end else if (i_attempt_contend) begin
                        retry_q <= retry_q;
                    end else if (i_attempt_err) begin
                        if (at_limit) begin
                            retry_q         <= `LC_RST_RETRY;
                            o_retry_give_up <= 1'b1;
                        end else begin
                            retry_q <= retry_q + 4'h1;
                        end
                    end else begin
                        retry_q <= `LC_RST_RETRY;
                    end
                end
                // a request landing with an attempt end is kept
                if (ts_tick && cmd_pend_q[0]) begin
                    rearb_q <= 1'b1;
                end
            end
        end
    end

    // *****************************
    // line coding and pins
    // *****************************
    lc_src_t    src_sel;    // active receive source
    logic [2:0] rx_lvl;     // receive levels after inversion
    logic       rx_pick;    // selected receive level

    assign rx_lvl = rx2_q ^ {3{rx_invert}};

    assign src_sel = pulse_code_sel ? LC_SRC_DIFF
                   : lc_src_t'({diag_mode_hi, diag_mode_lo});

    always_comb begin
        rx_pick = rx_lvl[0];
        unique case (src_sel)
            LC_SRC_DIFF: rx_pick = rx_lvl[0];
            LC_SRC_COMP: rx_pick = rx_lvl[2];
            LC_SRC_TRUE: rx_pick = rx_lvl[1];
            LC_SRC_AUTO: begin
                rx_pick = i_diag_status[0] ? rx_lvl[1] :
                          i_diag_status[1] ? rx_lvl[2] : rx_lvl[0];
            end
        endcase
    end

    // pin and core outputs, all registered
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_txd                  <= 1'b1;
            o_txd_oe               <= 1'b0;
            o_rx_bus               <= 1'b1;
            o_timeslot_tick        <= 1'b0;
            o_sync_diag_clock      <= 1'b0;
            o_transmit_in_progress <= 1'b0;
            o_diag_active          <= 1'b1;
            o_pulse_code           <= 1'b0;
            o_module_autonomous    <= 1'b0;
            o_retry_count          <= `LC_RST_RETRY;
            o_bus_enable           <= 1'b0;
            o_osc_run              <= 1'b1;
        end else if (i_ce) begin
            o_txd <= ((mode_q == LC_ACTIVE) ? ~i_tx_dominant : 1'b1) ^ tx_invert;
            o_txd_oe               <= (mode_q == LC_ACTIVE);
            o_rx_bus               <= (mode_q == LC_ACTIVE) ? rx_pick : 1'b1;
            o_timeslot_tick        <= ts_tick;
            o_sync_diag_clock      <= (pulse_cnt_q != 2'h0);
            o_transmit_in_progress <= tx_progress_enable && i_tx_busy
                                   && !pulse_code_sel && (mode_q == LC_ACTIVE);
            o_diag_active          <= !pulse_code_sel;
            o_pulse_code           <= pulse_code_sel;
            o_module_autonomous    <= module_kind_sel;
            o_retry_count          <= retry_q;
            o_bus_enable           <= (mode_q == LC_ACTIVE);
            o_osc_run              <= (mode_q != LC_SLEEP);
        end
    end

endmodule

// >>> verif/lc_ctrl_chk_assertions.sv
// port relations of the control bank
// assumes a bind onto lc_ctrl_regs, one clock
`timescale 1ns/100ps
module lc_ctrl_chk (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_nrst,
    // watched inputs
    input wire logic       i_tx_busy,
    input wire logic       i_attempt_done,
    input wire logic       i_attempt_contend,
    // watched outputs
    input wire logic       o_txd_oe,
    input wire logic       o_bus_enable,
    input wire logic       o_rx_bus,
    input wire logic       o_osc_run,
    input wire logic       o_pulse_code,
    input wire logic       o_diag_active,
    input wire logic       o_timeslot_tick,
    input wire logic       o_sync_diag_clock,
    input wire logic       o_transmit_in_progress,
    input wire logic [3:0] o_retry_count,
    input wire logic       o_retry_give_up,
    input wire logic       o_rearbitrate
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ****
    // helper: ticks seen while the pulse is high
    // ****
    logic [1:0] hi_q; // saturates, two is enough
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            hi_q <= 2'h0;
        else if (!o_sync_diag_clock)
            hi_q <= 2'h0;
        else if (o_timeslot_tick && hi_q != 2'h3)
            hi_q <= hi_q + 2'h1;
    end
    sequence s_no_giveup; !o_retry_give_up ##1 !o_retry_give_up; endsequence
    sequence s_rearb_end; o_retry_count == 4'h0 ##1 !o_rearbitrate; endsequence
    drv_active_a: assert property (
        !o_bus_enable |-> !o_txd_oe) else $error("driver on outside active");
    idle_rx_a: assert property (
        !o_bus_enable |-> o_rx_bus) else $error("bus not free outside active");
    pulse_nodiag_a: assert property (
        o_pulse_code |-> !o_diag_active) else $error("diagnosis on in pulsed");
    sleep_off_a: assert property (
        !o_osc_run |-> !o_bus_enable) else $error("bus enabled while asleep");
    giveup_clear_a: assert property (
        o_retry_give_up |=> !o_retry_give_up && o_retry_count == 4'h0)
        else $error("give up not a clearing pulse");
    contend_keep_a: assert property (
        i_attempt_done && i_attempt_contend |=> s_no_giveup)
        else $error("contention gave up");
    rearb_pulse_a: assert property (
        o_rearbitrate |=> s_rearb_end) else $error("rearbitrate pulse bad");
    diag_pulse_a: assert property (
        $fell(o_sync_diag_clock) |-> hi_q >= 2'h2) else $error("diag pulse short");
    tip_gate_a: assert property (
        o_transmit_in_progress |-> $past(i_tx_busy)) else $error("progress w/o busy");
    ts_space_a: assert property (
        o_timeslot_tick |=> !o_timeslot_tick [*8]) else $error("timeslot too short");
endmodule

// >>> verif/lc_host.sv
// host model driving the multiplexed bus pins
// assumes the bench calls wr and rd by hierarchy
`timescale 1ns/100ps
module lc_host (
    // clock
    input  wire logic  i_clk,
    // bus pins
    output logic       o_ale,
    output logic       o_cs_n,
    output logic       o_rd_n,
    output logic       o_wr_n,
    output logic [7:0] o_ad
);
    initial begin
        o_ale  = 1'b0;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_ad   = 8'h00;
    end
    // address phase, pins pass two sync flops
    task adr(input logic [7:0] a);
        @(negedge i_clk);
        o_ale = 1'b1;
        o_ad  = a;
        repeat (4) @(negedge i_clk);
        o_ale = 1'b0;
    endtask
    // data held past the strobe rise, then inverted
    task wr(input logic [7:0] a, input logic [7:0] d);
        adr(a);
        o_ad   = d;
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        repeat (6) @(negedge i_clk);
        o_wr_n = 1'b1;
        repeat (3) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_ad   = ~d;
        repeat (4) @(negedge i_clk);
    endtask
    // released lines show the inverse, never a stale value
    task rd(input logic [7:0] a);
        adr(a);
        o_ad   = ~a;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        repeat (6) @(negedge i_clk);
        o_rd_n = 1'b1;
        o_cs_n = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask
endmodule

// >>> verif/test_lc_ctrl_regs.sv
// self-checking bench of the control bank
// assumes the host model and the bound checker
`timescale 1ns/100ps
`include "lc_ctrl_params.svh"
module test_lc_ctrl_regs;
    logic       i_clk = 1'b0;
    logic       i_nrst = 1'b0;
    logic       ale, cs_n, rd_n, wr_n;
    logic [7:0] ad, o_ad, r;
    logic [2:0] rx = 3'h0;     // diff, true, comp
    logic [2:0] ds = 3'h1;     // diagnosis status from the core
    logic       dom = 1'b0, busy = 1'b0, go_t = 1'b0, go_r = 1'b0;
    logic       a_d = 1'b0, a_e = 1'b0, a_c = 1'b0;
    logic       o_ad_oe, txd, oe, rxb, sync_diag_clock, tick, kind, gu, rb, osc, transmit_in_progress, dga, pc, ben;
    logic [3:0] cnt;
    logic [7:0] exp_q[$];      // expected read bytes, oldest first
    int         n_errors = 0, num_checks = 0, n_oe = 0, n_gu = 0, n_rb = 0, n_sdc = 0;
    logic       oe_p = 1'b0, sdc_p = 1'b0;
    int         c, k;
    int         sel[8] = '{0, 2, 1, 2, 0, 2, 1, 1};
    int         cnt_e[6] = '{1, 1, 2, 0, 1, 0};
    logic [1:0] ev[6] = '{2'b10, 2'b01, 2'b10, 2'b10, 2'b10, 2'b00};
    always #2 i_clk = ~i_clk;
    lc_host host (.i_clk, .o_ale(ale), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ad(ad));
    lc_ctrl_regs dut_u (.i_clk, .i_nrst, .i_ce(1'b1), .i_ale(ale), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ad(ad), .o_ad, .o_ad_oe, .i_rx_line_diff(rx[0]),
        .i_rx_line_true(rx[1]), .i_rx_line_comp(rx[2]), .o_txd(txd), .o_txd_oe(oe),
        .i_tx_dominant(dom), .i_tx_busy(busy), .i_attempt_done(a_d), .i_attempt_err(a_e),
        .i_attempt_contend(a_c), .i_diag_status(ds), .i_tx_going(go_t),
        .i_rx_going(go_r), .o_rx_bus(rxb), .o_timeslot_tick(tick),
        .o_sync_diag_clock(sync_diag_clock), .o_transmit_in_progress(transmit_in_progress), .o_diag_active(dga),
        .o_pulse_code(pc), .o_module_autonomous(kind), .o_retry_count(cnt),
        .o_retry_give_up(gu), .o_rearbitrate(rb), .o_bus_enable(ben), .o_osc_run(osc));
    // ****
    // comparison and scoreboard
    // ****
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // watcher: each read answer takes the oldest note
    always @(negedge i_clk) begin
        if (o_ad_oe === 1'b1 && oe_p !== 1'b1) begin
            n_oe++;
            check(o_ad, exp_q.size() ? exp_q.pop_front() : ~o_ad);
        end
        n_gu  += (gu === 1'b1);
        n_rb  += (rb === 1'b1);
        n_sdc += (sync_diag_clock === 1'b1 && sdc_p !== 1'b1);
        oe_p  = o_ad_oe;
        sdc_p = sync_diag_clock;
    end
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task att(input logic [1:0] e);
        {a_e, a_c} = e;
        a_d = 1'b1;
        cyc(1);
        a_d = 1'b0;
        cyc(3);
    endtask
    // cycles between two events, sdc rises or ticks
    task gap(input bit s);
        k = n_sdc;
        c = 0;
        while ((s ? n_sdc == k : tick !== 1'b1) && c < 2000) begin cyc(1); c++; end
        k = n_sdc;
        cyc(1);
        c = 0;
        while ((s ? n_sdc == k : tick !== 1'b1) && c < 2000) begin cyc(1); c++; end
    endtask
    task summarize;
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        summarize;
    end
    initial begin
        cyc(2);
        i_nrst = 1'b1;
        r = 8'($urandom(64170));
        {go_t, go_r, rx} = 5'($urandom());
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h04, {3'b001, 3'h1, go_t, go_r});
        host.wr(8'h00, (r | 8'h08) & 8'hFB);
        rd(8'h00, (r | 8'h08) & 8'hFB);
        check({6'h0, pc, dga}, 8'h02);
        host.wr(8'h01, {r[7:4], `LC_REVISION_CODE, r[0]});
        rd(8'h01, {r[7:4], `LC_REVISION_CODE, r[0]});
        check(8'(kind), 8'(r[0]));
        k = n_oe;
        host.rd(8'h03);
        host.rd(8'h40);
        check(8'(n_oe - k), 8'h00);
        for (int n = 1; n < 3; n++) begin
            host.wr(8'h00, 8'(n << 4));
            gap(0);
            check(8'(c + 1 == 16 * n), 8'h01);
        end
        host.wr(8'h03, 8'h10);
        cyc(80);
        check({6'h0, oe, ben}, 8'h03);
        busy = 1'b1;
        for (int m = 0; m < 8; m++) begin
            dom = m[0];
            ds  = {1'b0, !m[2], m[2]};
            host.wr(8'h02, 8'(m[1:0] << 2 | m[0] << 1));
            host.wr(8'h00, {4'h2, 2'b00, m[2], m[2]});
            cyc(6);
            check(8'(rxb), 8'(rx[sel[m]] ^ m[2]));
            check(8'(transmit_in_progress), 8'(m[0]));
            check(8'(txd), 8'(!m[0] ^ m[2]));
        end
        host.wr(8'h01, {4'h2, `LC_REVISION_CODE, 1'b0});
        for (int i = 0; i < 6; i++) begin
            att(ev[i]);
            check(8'(cnt), 8'(cnt_e[i]));
        end
        check(8'(n_gu), 8'h01);
        att(2'b10);
        host.wr(8'h03, 8'h08);
        cyc(80);
        att(2'b10);
        check({3'h0, cnt, rb === 1'b0, n_rb == 1}, 8'h03);
        host.wr(8'h03, 8'h40);
        cyc(80);
        check(8'(osc), 8'h00);
        rd(8'h04, {3'b010, 3'h1, go_t, go_r});
        host.wr(8'h03, 8'h20);
        host.wr(8'h03, 8'h00);
        cyc(80);
        check({6'h0, oe, ben}, 8'h00);
        rd(8'h04, {3'b001, 3'h1, go_t, go_r});
        host.wr(8'h03, 8'h80);
        cyc(8);
        rd(8'h00, 8'h00);
        host.wr(8'h00, 8'h10);
        host.wr(8'h02, 8'h01);
        gap(1);
        check(8'(c + 1 == 1024), 8'h01);
        host.wr(8'h02, 8'h00);
        k = n_sdc;
        cyc(1100);
        check(8'(n_sdc - k), 8'h00);
        host.wr(8'h03, 8'h01);
        cyc(120);
        check(8'(n_sdc - k), 8'h01);
        summarize;
    end
endmodule
bind lc_ctrl_regs lc_ctrl_chk chk_u (.i_clk, .i_nrst, .i_tx_busy, .i_attempt_done,
    .i_attempt_contend, .o_txd_oe, .o_bus_enable, .o_rx_bus, .o_osc_run, .o_pulse_code,
    .o_diag_active, .o_timeslot_tick, .o_sync_diag_clock, .o_transmit_in_progress,
    .o_retry_count, .o_retry_give_up, .o_rearbitrate);
